//--- lmie_pkg.sv
// Shared constants and types for the move/logic instruction executor
package lmie_pkg;

   localparam int unsigned INSTR_W = 14;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned FILE_DEPTH = 128;

   // Field positions inside the instruction word
   localparam int unsigned OPC_HI = 13;
   localparam int unsigned OPC_LO = 8;
   localparam int unsigned DEST_POS = 7;
   localparam int unsigned LIT_GRP_HI = 13;
   localparam int unsigned LIT_GRP_LO = 10;

   // Opcode patterns (upper six bits, upper four for the literal group, low seven for idle)
   localparam logic [5:0] OPC_OR_REG = 6'h04;
   localparam logic [5:0] OPC_COPY_REG = 6'h08;
   localparam logic [5:0] OPC_ZERO_GRP = 6'h00;
   localparam logic [3:0] OPC_LOAD_IMM = 4'hC;
   localparam logic [6:0] IDLE_LOW7 = 7'h00;

   // Values after reset
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic ZERO_RST = 1'b0;

   typedef enum logic [2:0] {
      LMIE_OP_IDLE = 3'h0,
      LMIE_OP_OR = 3'h1,
      LMIE_OP_COPY = 3'h3,
      LMIE_OP_STORE = 3'h2,
      LMIE_OP_LOAD = 3'h6,
      LMIE_OP_BAD = 3'h7
   } lmie_op_e;

   typedef struct packed {
      lmie_op_e op;
      logic to_file;
      logic [6:0] addr;
      logic [7:0] lit;
   } lmie_dec_s;

   typedef struct packed {
      logic [7:0] acc;
      logic zero;
      logic retire;
      logic illegal;
   } lmie_state_s;

endpackage

//--- lmie_decode.sv
// Combinational decoder of the instruction word into an operation record
`timescale 1ns/1ps
module lmie_decode (
   // Instruction word in
   input wire logic [13:0] instr,
   // Decoded record out
   output lmie_pkg::lmie_dec_s dec
);

   always_comb begin
      dec.op = lmie_pkg::LMIE_OP_BAD;
      dec.to_file = instr[lmie_pkg::DEST_POS];
      dec.addr = instr[6:0];
      dec.lit = instr[7:0];
      if (instr[lmie_pkg::LIT_GRP_HI:lmie_pkg::LIT_GRP_LO] ==
          lmie_pkg::OPC_LOAD_IMM) begin
         // Don't-care bits 9:8 are ignored, whatever the assembler put there
         dec.op = lmie_pkg::LMIE_OP_LOAD;
      end else if (instr[lmie_pkg::OPC_HI:lmie_pkg::OPC_LO] ==
                   lmie_pkg::OPC_OR_REG) begin
         dec.op = lmie_pkg::LMIE_OP_OR;
      end else if (instr[lmie_pkg::OPC_HI:lmie_pkg::OPC_LO] ==
                   lmie_pkg::OPC_COPY_REG) begin
         dec.op = lmie_pkg::LMIE_OP_COPY;
      end else if (instr[lmie_pkg::OPC_HI:lmie_pkg::OPC_LO] ==
                   lmie_pkg::OPC_ZERO_GRP) begin
         if (instr[lmie_pkg::DEST_POS]) begin
            dec.op = lmie_pkg::LMIE_OP_STORE;
            dec.to_file = 1'b1;
         end else if (instr[6:0] == lmie_pkg::IDLE_LOW7) begin
            dec.op = lmie_pkg::LMIE_OP_IDLE;
         end
      end
   end

endmodule // lmie_decode

//--- lmie_core.sv
// Executor for OR-with-register, copy, store, load-immediate and idle ops
// Notes on behaviour
// - OR accumulator with addressed register; zero flag reflects the result.
// - OR result goes to accumulator when target is 0, register when 1.
// - Copy moves register to accumulator, or rewrites same register.
// - Copy sets zero flag from moved value, also when target is 1.
// - Store writes accumulator to 7-bit addressed register; flags untouched.
// - Load puts 8-bit immediate in accumulator; flags untouched.
`timescale 1ns/1ps
module lmie_core #(
   parameter int unsigned DEPTH = lmie_pkg::FILE_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Instruction issue, one per cycle
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   // Observation port into the file registers
   input wire logic [6:0] peek_addr,
   output logic [7:0] peek_data,
   // Core state
   output logic [7:0] acc,
   output logic zero_flag,
   output logic pc_advance,
   output logic illegal_op
);

   lmie_pkg::lmie_dec_s dec;
   lmie_pkg::lmie_state_s st_q;
   lmie_pkg::lmie_state_s st_d;
   logic [7:0] file_mem [DEPTH];
   logic [7:0] file_rd;
   logic [7:0] result;
   logic file_we;
   logic [7:0] file_wd;
   logic [7:0] peek_q;

   lmie_decode u_decode (
      .instr(instr),
      .dec(dec)
   );

   assign file_rd = file_mem[dec.addr];

   always_comb begin
      st_d = st_q;
      st_d.retire = 1'b0;
      st_d.illegal = 1'b0;
      file_we = 1'b0;
      file_wd = st_q.acc;
      result = st_q.acc | file_rd;
      if (instr_valid) begin
         st_d.retire = 1'b1;
         unique case (dec.op)
            lmie_pkg::LMIE_OP_OR: begin
               result = st_q.acc | file_rd;
               st_d.zero = (result == 8'h00);
               if (dec.to_file) begin
                  file_we = 1'b1;
                  file_wd = result;
               end else begin
                  st_d.acc = result;
               end
            end
            lmie_pkg::LMIE_OP_COPY: begin
               result = file_rd;
               st_d.zero = (file_rd == 8'h00);
               if (dec.to_file) begin
                  file_we = 1'b1;
                  file_wd = file_rd;
               end else begin
                  st_d.acc = file_rd;
               end
            end
            lmie_pkg::LMIE_OP_STORE: begin
               file_we = 1'b1;
               file_wd = st_q.acc;
            end
            lmie_pkg::LMIE_OP_LOAD: begin
               st_d.acc = dec.lit;
            end
            lmie_pkg::LMIE_OP_IDLE: begin
               st_d.acc = st_q.acc;
            end
            lmie_pkg::LMIE_OP_BAD: begin
               // Foreign opcodes belong to other units; flagged, not executed
               st_d.illegal = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q.acc <= lmie_pkg::ACC_RST;
         st_q.zero <= lmie_pkg::ZERO_RST;
         st_q.retire <= 1'b0;
         st_q.illegal <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // File contents are data, not control, so they are left out of reset
   always_ff @(posedge clk_sys) begin
      if (file_we) begin
         file_mem[dec.addr] <= file_wd;
      end
      peek_q <= file_mem[peek_addr];
   end

   assign acc = st_q.acc;
   assign zero_flag = st_q.zero;
   assign pc_advance = st_q.retire;
   assign illegal_op = st_q.illegal;
   assign peek_data = peek_q;

   // Checks
   logic go_or;
   logic go_copy;
   logic go_store;
   logic go_load;
   logic go_idle;
   assign go_or = instr_valid && dec.op == lmie_pkg::LMIE_OP_OR;
   assign go_copy = instr_valid && dec.op == lmie_pkg::LMIE_OP_COPY;
   assign go_store = instr_valid && dec.op == lmie_pkg::LMIE_OP_STORE;
   assign go_load = instr_valid && dec.op == lmie_pkg::LMIE_OP_LOAD;
   assign go_idle = instr_valid && dec.op == lmie_pkg::LMIE_OP_IDLE;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   chk_or_zero_flag: assert property (
      go_or |=> zero_flag == ($past(st_q.acc | file_rd) == 8'h00))
      else $error("or: zero flag does not match result");
   chk_or_dest_acc: assert property (
      go_or && !dec.to_file |=> acc == $past(st_q.acc | file_rd))
      else $error("or: accumulator not loaded with result");
   chk_or_dest_file: assert property (
      go_or && dec.to_file |=> file_mem[$past(dec.addr)] ==
         $past(st_q.acc | file_rd) && $stable(acc))
      else $error("or: register not written or accumulator changed");
   chk_copy_to_acc: assert property (
      go_copy && !dec.to_file |=> acc == $past(file_rd))
      else $error("copy: accumulator not loaded");
   chk_copy_zero_test: assert property (
      go_copy && dec.to_file |=> $stable(acc) &&
         zero_flag == ($past(file_rd) == 8'h00) &&
         file_mem[$past(dec.addr)] == $past(file_rd))
      else $error("copy: zero test altered state or flag wrong");
   chk_store_write: assert property (
      go_store |=> file_mem[$past(dec.addr)] == $past(acc) &&
         $stable(zero_flag) && $stable(acc))
      else $error("store: wrong data or flag changed");
   chk_load_imm: assert property (
      go_load |=> acc == $past(instr[7:0]) && $stable(zero_flag))
      else $error("load: accumulator or flag wrong");
   chk_idle_quiet: assert property (
      go_idle |=> $stable(acc) && $stable(zero_flag) && pc_advance)
      else $error("idle: state changed or no advance");
   chk_retire_once: assert property (
      !instr_valid |=> !pc_advance)
      else $error("advance without an instruction");

   cov_copy_zero: cover property (go_copy && dec.to_file && file_rd == 8'h00);
   cov_or_then_store: cover property (go_or ##1 go_store);
   cov_load_idle: cover property (go_load ##1 go_idle);

endmodule // lmie_core

//--- lmie_core_test.sv
// Self-checking bench for the move/logic instruction executor
`timescale 1ns/1ps
module lmie_core_test;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [6:0] peek_addr = 7'h00;
   logic [7:0] peek_data, acc;
   logic zero_flag, pc_advance, illegal_op;
   logic [7:0] mem_m [128];
   logic [7:0] acc_m = 8'h00;
   logic z_m = 1'b0;
   logic [31:0] rnd = 32'h0001_7436;
   logic [9:0] exp_q [$];
   logic [7:0] peek_q [$];
   logic peek_req = 1'b0;
   logic peek_due = 1'b0;
   int mismatches = 0;
   int samples_checked = 0;

   always #2 clk_sys = ~clk_sys;

   lmie_core lmie_core_inst (.clk_sys(clk_sys), .rst_n(rst_n),
      .instr_valid(instr_valid), .instr(instr), .peek_addr(peek_addr),
      .peek_data(peek_data), .acc(acc), .zero_flag(zero_flag),
      .pc_advance(pc_advance), .illegal_op(illegal_op));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic cmp(input string what, input logic [9:0] e,
                      input logic [9:0] s);
      samples_checked++;
      if (e !== s) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, e, s);
      end
   endtask

   task automatic test_done();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Peek expectation is queued before the model update, so it holds pre-write contents
   task automatic issue(input logic [13:0] w, input logic pk);
      logic [7:0] f, r;
      logic ill;
      @(negedge clk_sys);
      peek_addr = rnd[22:16];
      peek_req = pk;
      if (pk) peek_q.push_back(mem_m[rnd[22:16]]);
      instr_valid = 1'b1;
      instr = w;
      f = mem_m[w[6:0]];
      ill = 1'b0;
      if (w[13:8] == 6'h04 || w[13:8] == 6'h08) begin
         r = (w[13:8] == 6'h04) ? (acc_m | f) : f;
         z_m = (r == 8'h00);
         if (w[7]) mem_m[w[6:0]] = r;
         else acc_m = r;
      end else if (w[13:7] == 7'h01) mem_m[w[6:0]] = acc_m;
      else if (w[13:10] == 4'hC) acc_m = w[7:0];
      else if (w != 14'h0000) ill = 1'b1;
      exp_q.push_back({acc_m, z_m, ill});
   endtask

   task automatic idle();
      @(negedge clk_sys);
      instr_valid = 1'b0;
      peek_req = 1'b0;
   endtask

   always @(posedge clk_sys) peek_due <= peek_req & rst_n;

   always @(negedge clk_sys) begin
      if (pc_advance === 1'b1) begin
         if (exp_q.size() == 0) cmp("advance", 10'h000, 10'h3FF);
         else cmp("state", exp_q.pop_front(), {acc, zero_flag, illegal_op});
      end
      if (peek_due) cmp("peek", {2'h0, peek_q.pop_front()}, {2'h0, peek_data});
   end

   initial begin
      logic [13:0] w;
      logic [7:0] k;
      int n;
      for (int i = 0; i < 16; i++) @(negedge clk_sys);
      rst_n = 1'b1;
      cmp("reset", 10'h000, {acc, zero_flag, illegal_op});
      // Fill every file register first; they hold no reset value
      for (int a = 0; a < 128; a++) begin
         rnd = xs(rnd);
         k = (rnd[3:0] == 4'h0) ? 8'h00 : rnd[11:4];
         issue({6'h30, k}, 1'b0);
         issue({7'h01, a[6:0]}, 1'b0);
      end
      for (int i = 0; i < 2000; i++) begin
         rnd = xs(rnd);
         k = (rnd[3:0] == 4'h0) ? 8'h00 : rnd[11:4];
         case (rnd[14:12])
            3'h0: w = {6'h04, rnd[15], rnd[22:16]};
            3'h1: w = {6'h08, rnd[15], rnd[22:16]};
            3'h2: w = {7'h01, rnd[22:16]};
            3'h3: w = {6'h30, k};
            3'h4: w = 14'h0000;
            3'h5: w = {6'h01, k};
            3'h6: w = {7'h00, rnd[22:16] | 7'h01};
            default: w = {6'h04, 1'b0, rnd[22:16]};
         endcase
         if (rnd[27:25] == 3'h0) idle();
         issue(w, 1'b1);
      end
      idle();
      n = 0;
      while ((exp_q.size() > 0 || peek_q.size() > 0) && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 100) mismatches++;
      test_done();
   end
endmodule // lmie_core_test
